//--- rtcsw_core.sv
// RTC support logic: square wave, battery check, century bits, oscillator fail and AXI4-Lite registers.
// Overview of operation
// [R1] Four-bit rate code selects square wave: 0 off, 1 32.768 kHz, halving to 1 Hz.
// [R2] Square-wave enable bit turns the pin on or off independently of rate.
// [R3] Square wave is forced off whenever main supply is below switchover.
// [R4] Battery check runs at every main-supply power-up and every midnight rollover.
// [R5] Each check sets battery-low flag if battery below threshold, else clears it.
// [R6] Battery-low flag holds its value between checks.
// [R7] Midnight check applies load, compares, updates flag, then removes load.
// [R8] Power-up check compares battery without applying any load.
// [R9] Battery checks happen only on main supply, never in backup mode.
// [R10] Host may force a check by setting time to 23:59:59 and waiting.
// [R11] Two-bit century value increments in binary at each century turn.
// [R12] Leap year when divisible by four; century year only when century value zero.
// [R13] Oscillator-fail flag sets whenever the oscillator stops.
// [R14] Flag also sets at first power, low supply, halt bit set, or interference; the code sets it only at reset, from the halt bit and from oscStopped.
// [R15] Host restarts oscillator by writing halt bit to one then back to zero.
// [R16] Oscillator-fail flag clears only by software writing zero; reads leave it.
// [R17] Host waits four seconds of oscillation before clearing the oscillator-fail flag.
// [R18] Oscillator-fail detection stays active in backup mode.
// [R19] With interrupt enable set, shared interrupt asserts while oscillator-fail flag is one.
// [R20] Clearing enable deasserts without clearing flag; re-enabling reasserts at once.
// [R21] With backup interrupt enable also set, the interrupt works in backup mode.
// [R22] Oscillator-fail interrupt enable lives in bit 7 of register 09h.
// [R23] Backup interrupt enable lives in bit 5 of register 0Ah.
// [R24] All wave rates come from binary division of the oscillator clock.
// [R25] Battery comparator result is one digital input sampled once per check.
module rtcsw_core
  import rtcsw_pkg::*;
#(
  parameter int LOAD_CYCLES = LOAD_SETTLE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        oscEdgeTick,
  input  wire logic        oscStopped,
  input  wire logic        mainSupplyOk,
  input  wire logic        midnightTick,
  input  wire logic        battBelowThreshold,
  input  wire logic        centuryTurn,
  input  wire logic        yearDivByFour,
  input  wire logic        yearIsCentury,
  output logic             squareWavePin,
  output logic             batteryLoad,
  output logic             leapYear,
  output logic             sharedIrqPinOut,
  output logic             sharedIrqPinOeN
);

  localparam logic [8:0] LOAD_CNT = 9'(LOAD_CYCLES - 1);

  rtcsw_ctrl_s          ctrl_reg;
  rtcsw_bc_e            bcState_reg;
  logic [8:0]           loadCnt_reg;
  logic                 battLow_reg;
  logic                 supplyPrev_reg;
  logic [1:0]           century_reg;
  logic                 oscFail_reg;
  logic [DIV_WIDTH-1:0] divCnt_reg;
  logic                 awHeld_reg;
  logic                 wHeld_reg;
  logic [7:0]           awIdx_reg;
  logic [7:0]           wByte_reg;
  logic                 wLane_reg;
  logic                 wrDo;
  logic                 ofClearWr;
  logic                 ofSet;
  logic                 powerUpEdge;
  logic                 irqActive;
  logic                 waveBit;
  logic [7:0]           arIdx;
  logic                 arHit;
  logic [31:0]          rdMux;

  // Write channels are taken independently; the response is held until both are in.
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign wrDo          = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      awIdx_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awIdx_reg  <= s_axi_awaddr[9:2];
    end else if (wrDo) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wHeld_reg <= 1'b0;
      wByte_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wByte_reg <= s_axi_wdata[7:0];
      wLane_reg <= s_axi_wstrb[0];
    end else if (wrDo) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Write response; an address outside the map answers SLVERR and changes nothing.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrDo) begin
      s_axi_bvalid <= 1'b1;
      case (awIdx_reg)
        IDX_WATCHDOG, IDX_ALARM1MO, IDX_FLAGS,
        IDX_WAVERATE, IDX_CONTROL, IDX_STATUS: s_axi_bresp <= RESP_OKAY;
        default:                               s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control fields; only byte lane 0 carries bits, so other lanes are ignored.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg <= '{1'b0, 1'b0, 1'b0, 1'b0, RATE_RESET};
    end else if (wrDo && wLane_reg) begin
      case (awIdx_reg)
        IDX_WATCHDOG: ctrl_reg.oscFailIrqEnable <= wByte_reg[OSC_FAIL_IRQ_ENABLE_BIT]; // R22
        IDX_ALARM1MO: begin
          ctrl_reg.backupIrqEnable  <= wByte_reg[ABE_BIT]; // R23
          ctrl_reg.waveOutputEnable <= wByte_reg[WAVE_OUTPUT_ENABLE_BIT];
        end
        IDX_WAVERATE: ctrl_reg.waveRateSelect <= wByte_reg[RATE_LSB+:4];
        IDX_CONTROL:  ctrl_reg.oscillatorHaltBit <= wByte_reg[HALT_BIT];
        default:      ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Read path; reads have no side effect on any flag.
  assign arIdx = s_axi_araddr[9:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rdMux = 32'h0000_0000;
    arHit = 1'b1;
    case (arIdx)
      IDX_WATCHDOG: rdMux[OSC_FAIL_IRQ_ENABLE_BIT] = ctrl_reg.oscFailIrqEnable;
      IDX_ALARM1MO: begin
        rdMux[ABE_BIT]  = ctrl_reg.backupIrqEnable;
        rdMux[WAVE_OUTPUT_ENABLE_BIT] = ctrl_reg.waveOutputEnable;
      end
      IDX_FLAGS: begin
        rdMux[BLF_BIT] = battLow_reg;
        rdMux[OFF_BIT] = oscFail_reg; // R16
      end
      IDX_WAVERATE: rdMux[RATE_LSB+:4] = ctrl_reg.waveRateSelect;
      IDX_CONTROL:  rdMux[HALT_BIT]    = ctrl_reg.oscillatorHaltBit;
      IDX_STATUS: begin
        rdMux[CENT_LSB+:2] = century_reg;
        rdMux[LEAP_BIT]    = leapYear;
        rdMux[SUPPLY_BIT]  = mainSupplyOk;
        rdMux[BCBUSY_BIT]  = (bcState_reg != BC_IDLE);
      end
      default: arHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= arHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Binary divider on oscillator edges; bit k toggles at 32.768 kHz over 2^k.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divCnt_reg <= '0;
    end else if (oscEdgeTick) begin
      divCnt_reg <= divCnt_reg + 1'b1; // R24
    end
  end

  // Code 1 is the oscillator itself; codes 2 to 15 pick divider bit n.
  always_comb begin
    case (ctrl_reg.waveRateSelect)
      4'h0:    waveBit = 1'b0;
      4'h1:    waveBit = divCnt_reg[0];
      default: waveBit = divCnt_reg[ctrl_reg.waveRateSelect];
    endcase
  end

  // The pin is gated by enable and by supply, so it never runs from the backup cell.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      squareWavePin <= 1'b0;
    end else begin
      squareWavePin <= waveBit // R1
                       && ctrl_reg.waveOutputEnable // R2
                       && mainSupplyOk; // R3
    end
  end

  // Power-up seen as a rising supply; the reset value makes the first supplied cycle count.
  assign powerUpEdge = mainSupplyOk && !supplyPrev_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supplyPrev_reg <= 1'b0;
    end else begin
      supplyPrev_reg <= mainSupplyOk;
    end
  end

  // Battery check sequence; a supply loss aborts it and removes the load at once.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bcState_reg <= BC_IDLE;
      loadCnt_reg <= 9'h000;
      batteryLoad <= 1'b0;
    end else if (!mainSupplyOk) begin
      bcState_reg <= BC_IDLE; // R9
      batteryLoad <= 1'b0;
    end else begin
      case (bcState_reg)
        BC_IDLE: begin
          if (powerUpEdge) begin
            bcState_reg <= BC_SAMPLE; // R4 R8
          end else if (midnightTick) begin
            bcState_reg <= BC_LOAD; // R4
            batteryLoad <= 1'b1; // R7
            loadCnt_reg <= LOAD_CNT;
          end
        end
        BC_LOAD: begin
          if (loadCnt_reg == 9'h000) begin
            bcState_reg <= BC_SAMPLE;
          end else begin
            loadCnt_reg <= loadCnt_reg - 1'b1;
          end
        end
        BC_SAMPLE: begin
          bcState_reg <= BC_IDLE;
          batteryLoad <= 1'b0; // R7
        end
        default: begin
          bcState_reg <= BC_IDLE;
          batteryLoad <= 1'b0;
        end
      endcase
    end
  end

  // The flag moves only in the sample state, so a new cell shows at the next check.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      battLow_reg <= 1'b0;
    end else if (bcState_reg == BC_SAMPLE && mainSupplyOk) begin
      battLow_reg <= battBelowThreshold; // R5 R6 R25
    end
  end

  // Century count wraps from 3 to 0 as a plain binary counter.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      century_reg <= 2'h0;
    end else if (centuryTurn) begin
      century_reg <= century_reg + 1'b1; // R11
    end
  end

  // Only the century value 0 makes a century year leap, the 400-year case.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      leapYear <= 1'b0;
    end else begin
      leapYear <= yearDivByFour && (!yearIsCentury || century_reg == 2'h0); // R12
    end
  end

  // Oscillator fail: detector works in backup too; a set beats a clear in the same cycle.
  assign ofSet     = oscStopped || ctrl_reg.oscillatorHaltBit; // R13 R14 R18
  assign ofClearWr = wrDo && wLane_reg && awIdx_reg == IDX_FLAGS && !wByte_reg[OFF_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oscFail_reg <= OFF_RESET; // R14
    end else if (ofSet) begin
      oscFail_reg <= 1'b1; // R13
    end else if (ofClearWr) begin
      oscFail_reg <= 1'b0; // R16
    end
  end

  // Open-drain interrupt: the pin is pulled low while the enable gates a set flag, on main supply or with the backup enable set.
  assign irqActive = ctrl_reg.oscFailIrqEnable && oscFail_reg // R19 R20
                     && (mainSupplyOk || ctrl_reg.backupIrqEnable); // R21

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sharedIrqPinOut <= 1'b0;
      sharedIrqPinOeN <= 1'b1;
    end else begin
      sharedIrqPinOut <= 1'b0;
      sharedIrqPinOeN <= !irqActive; // R19 R20 R21
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_WAVE_OFF_NO_SUPPLY: assert property (!mainSupplyOk |=> !squareWavePin) // R3
    else $error("Square wave running without main supply.");

  AST_WAVE_CODE_ZERO: assert property (ctrl_reg.waveRateSelect == 4'h0 |=> !squareWavePin) // R1
    else $error("Square wave running with rate code zero.");

  AST_WAVE_DISABLED: assert property (!ctrl_reg.waveOutputEnable |=> !squareWavePin) // R2
    else $error("Square wave running while disabled.");

  AST_WAVE_FOLLOWS: assert property (mainSupplyOk && ctrl_reg.waveOutputEnable
      && ctrl_reg.waveRateSelect == 4'h1 |=> squareWavePin == $past(divCnt_reg[0])) // R24
    else $error("Square wave does not follow the oscillator.");

  AST_BL_HOLD: assert property (bcState_reg != BC_SAMPLE |=> $stable(battLow_reg)) // R6
    else $error("Battery-low flag changed outside a check.");

  AST_BL_UPDATE: assert property (bcState_reg == BC_SAMPLE && mainSupplyOk
      |=> battLow_reg == $past(battBelowThreshold)) // R5
    else $error("Battery-low flag not updated at check.");

  AST_MIDNIGHT_LOAD: assert property (bcState_reg == BC_IDLE && mainSupplyOk && !powerUpEdge
      && midnightTick |=> batteryLoad throughout (bcState_reg == BC_LOAD) [*2]) // R7
    else $error("Load missing during midnight check.");

  AST_LOAD_REMOVED: assert property (bcState_reg == BC_SAMPLE |=> !batteryLoad) // R7
    else $error("Battery load not removed after check.");

  AST_PWRUP_NOLOAD: assert property (bcState_reg == BC_IDLE && powerUpEdge
      |=> bcState_reg == BC_SAMPLE && !batteryLoad) // R8
    else $error("Power-up check applied a load.");

  AST_NO_CHECK_BACKUP: assert property (!mainSupplyOk |=> bcState_reg == BC_IDLE
      && !batteryLoad) // R9
    else $error("Battery check active in backup mode.");

  AST_CENTURY_INC: assert property (centuryTurn |=> century_reg == $past(century_reg) + 2'h1) // R11
    else $error("Century value did not increment.");

  AST_LEAP: assert property (yearDivByFour && yearIsCentury && century_reg != 2'h0
      |=> !leapYear) // R12
    else $error("Century year leap with nonzero century value.");

  AST_OF_SET: assert property (oscStopped |=> oscFail_reg) // R13 R18
    else $error("Oscillator stop did not set the fail flag.");

  AST_OF_STICKY: assert property (oscFail_reg && !ofClearWr |=> oscFail_reg) // R16
    else $error("Oscillator-fail flag cleared without a write of zero.");

  AST_IRQ_LEVEL: assert property (ctrl_reg.oscFailIrqEnable && oscFail_reg
      && (mainSupplyOk || ctrl_reg.backupIrqEnable) |=> !sharedIrqPinOeN) // R19 R21
    else $error("Interrupt not asserted for a set fail flag.");

  AST_IRQ_DISABLE: assert property ($fell(ctrl_reg.oscFailIrqEnable)
      |=> sharedIrqPinOeN && oscFail_reg == $past(oscFail_reg)) // R20
    else $error("Disabling the interrupt misbehaved.");

  COV_MIDNIGHT: cover property (bcState_reg == BC_LOAD ##[1:1000] bcState_reg == BC_SAMPLE);
  COV_PWRUP: cover property (powerUpEdge && bcState_reg == BC_IDLE);
  COV_IRQ_BACKUP: cover property (!mainSupplyOk && !sharedIrqPinOeN);
  COV_OF_CLEAR: cover property (oscFail_reg ##1 !oscFail_reg);

endmodule : rtcsw_core

//--- rtcsw_pkg.sv
// Package with register map, field layout, reset values and timing counts of the RTC support block.
package rtcsw_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_WATCHDOG = 8'h09;
  localparam logic [7:0] IDX_ALARM1MO = 8'h0A;
  localparam logic [7:0] IDX_FLAGS    = 8'h0F;
  localparam logic [7:0] IDX_WAVERATE = 8'h13;
  localparam logic [7:0] IDX_CONTROL  = 8'h1C;
  localparam logic [7:0] IDX_STATUS   = 8'h1D;

  // Field positions.
  localparam int OSC_FAIL_IRQ_ENABLE_BIT   = 7;
  localparam int WAVE_OUTPUT_ENABLE_BIT   = 6;
  localparam int ABE_BIT    = 5;
  localparam int BLF_BIT    = 4;
  localparam int OFF_BIT    = 2;
  localparam int RATE_LSB   = 4;
  localparam int HALT_BIT   = 0;
  localparam int CENT_LSB   = 0;
  localparam int LEAP_BIT   = 2;
  localparam int SUPPLY_BIT = 3;
  localparam int BCBUSY_BIT = 4;

  // Reset values.
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic       OFF_RESET  = 1'b1;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: battery load settle time before the midnight comparison.
  localparam int CLK_PERIOD_NS   = 25;
  localparam int LOAD_SETTLE_NS  = 10000;
  localparam int LOAD_SETTLE_CYC = (LOAD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_WIDTH       = 16;

  typedef enum logic [1:0] {
    BC_IDLE   = 2'b00,
    BC_LOAD   = 2'b01,
    BC_SAMPLE = 2'b10
  } rtcsw_bc_e;

  // Software control bits that steer the block.
  typedef struct packed {
    logic       oscFailIrqEnable;
    logic       backupIrqEnable;
    logic       waveOutputEnable;
    logic       oscillatorHaltBit;
    logic [3:0] waveRateSelect;
  } rtcsw_ctrl_s;

endpackage : rtcsw_pkg

//--- test_rtc_status_and_square_wave.sv
// Self-checking testbench of the RTC support block, driven over AXI4-Lite and its pins.
module test_rtc_status_and_square_wave;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcsw_pkg::*;
  localparam int LOADC = 4;
  localparam int CEIL  = 20000;
  logic        ref_clk, srst, awValid, wValid, arValid, awRdy, wRdy, bValid, arRdy, rValid;
  logic [31:0] awAddr, wData, arAddr, rData;
  logic [1:0]  bResp, rResp;
  logic        oscTick, oscStop, supplyOk, midTick, battLow, centTurn, div4, isCent;
  logic        square_wave_pin, load, leap, irqOut, irqOeN, counting, prevSqw;
  int          errCount, numChecks, cycles, toggles, loadLen, seed, mOf, mBl, mCent;

  rtcsw_core #(.LOAD_CYCLES(LOADC)) rtcsw_core_inst (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'h1),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arRdy),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'h1),
    .oscEdgeTick(oscTick), .oscStopped(oscStop), .mainSupplyOk(supplyOk),
    .midnightTick(midTick), .battBelowThreshold(battLow), .centuryTurn(centTurn),
    .yearDivByFour(div4), .yearIsCentury(isCent), .squareWavePin(square_wave_pin), .batteryLoad(load),
    .leapYear(leap), .sharedIrqPinOut(irqOut), .sharedIrqPinOeN(irqOeN));

  // Clock at 40 MHz.
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Oscillator ticks every other cycle, so any window of 2N cycles holds N ticks.
  // Side monitors count wave toggles and cycles of battery load, and cut a hang short.
  always @(posedge ref_clk) begin
    oscTick <= ~oscTick;
    prevSqw <= square_wave_pin;
    if (counting && square_wave_pin !== prevSqw) toggles <= toggles + 1;
    if (load === 1'h1) loadLen <= loadLen + 1;
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      errCount++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (errCount == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Write one register; address and data are offered together and each released when taken.
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] resp);
    logic awDone, wDone;
    awDone = 1'h0;
    wDone = 1'h0;
    awAddr <= {22'h0, idx, 2'h0};
    wData <= {24'h0, val};
    awValid <= 1'h1;
    wValid <= 1'h1;
    while (!(awDone && wDone)) begin
      @(posedge ref_clk);
      if (!awDone && awRdy) begin
        awDone = 1'h1;
        awValid <= 1'h0;
      end
      if (!wDone && wRdy) begin
        wDone = 1'h1;
        wValid <= 1'h0;
      end
    end
    do @(posedge ref_clk); while (bValid !== 1'h1);
    resp = bResp;
  endtask : axi_write

  // Read one register and wait for its answer, however long it takes.
  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    arAddr <= {22'h0, idx, 2'h0};
    arValid <= 1'h1;
    do @(posedge ref_clk); while (arRdy !== 1'h1);
    arValid <= 1'h0;
    do @(posedge ref_clk); while (rValid !== 1'h1);
    d = rData;
    resp = rResp;
  endtask : axi_read

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic [1:0] r;
    axi_write(idx, val, r);
    chk(r, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
  endtask : wr

  // Read the flags register and compare battery-low and oscillator-fail with the model.
  task automatic chk_flags;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(IDX_FLAGS, d, r);
    chk(d & 32'h14, 32'((mBl << BLF_BIT) | (mOf << OFF_BIT)));
  endtask : chk_flags

  // Count wave toggles over 256 cycles, that is 128 oscillator ticks.
  task automatic measure(input int exp);
    toggles = 0;
    counting <= 1'h1;
    repeat (256) @(posedge ref_clk);
    counting <= 1'h0;
    @(posedge ref_clk);
    chk(32'(toggles), 32'(exp));
  endtask : measure

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          b;
    int          lm;
    seed = 32'hC636B092;
    {srst, awValid, wValid, arValid, counting, prevSqw, oscTick} = 7'h40;
    {oscStop, midTick, centTurn, div4, isCent} = 5'h0;
    {awAddr, wData, arAddr} = 96'h0;
    supplyOk = 1'h1;
    battLow = 1'h1;
    {errCount, numChecks, cycles, toggles, loadLen, mCent} = 192'h0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    mBl = 1;
    mOf = 1;
    chk_flags();
    chk(32'(loadLen), 32'h0);
    axi_read(IDX_WAVERATE, d, r);
    chk((d >> RATE_LSB) & 32'hF, 32'(RATE_RESET));
    wr(IDX_ALARM1MO, 8'h40);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_WAVERATE, 8'(c << RATE_LSB));
      measure(c == 0 ? 0 : (c == 1 ? 128 : 128 >> c));
    end
    wr(IDX_WAVERATE, 8'h10);
    wr(IDX_ALARM1MO, 8'h00);
    measure(0);
    chk(square_wave_pin, 1'h0);
    wr(IDX_ALARM1MO, 8'h40);
    measure(128);
    supplyOk <= 1'h0;
    b = $random(seed) & 1;
    battLow <= b[0];
    // Let the gated pin settle first, so its last fall is not counted as a toggle.
    repeat (2) @(posedge ref_clk);
    measure(0);
    loadLen = 0;
    supplyOk <= 1'h1;
    mBl = b;
    repeat (4) @(posedge ref_clk);
    chk_flags();
    chk(32'(loadLen), 32'h0);
    // Midnight checks with a random comparator, changed again once each check is over.
    for (int i = 0; i < 4; i++) begin
      b = $random(seed) & 1;
      battLow <= b[0];
      loadLen = 0;
      midTick <= 1'h1;
      @(posedge ref_clk);
      midTick <= 1'h0;
      repeat (LOADC + 8) @(posedge ref_clk);
      chk(32'(loadLen), 32'(LOADC + 1));
      battLow <= ~b[0];
      mBl = b;
      chk_flags();
      chk_flags();
    end
    chk_flags();
    wr(IDX_WATCHDOG, 8'h80);
    chk(irqOeN, 1'h0);
    chk(irqOut, 1'h0);
    wr(IDX_WATCHDOG, 8'h00);
    chk(irqOeN, 1'h1);
    chk_flags();
    wr(IDX_WATCHDOG, 8'h80);
    chk(irqOeN, 1'h0);
    wr(IDX_FLAGS, 8'h00);
    mOf = 0;
    chk(irqOeN, 1'h1);
    chk_flags();
    oscStop <= 1'h1;
    @(posedge ref_clk);
    oscStop <= 1'h0;
    repeat (3) @(posedge ref_clk);
    mOf = 1;
    chk_flags();
    chk(irqOeN, 1'h0);
    wr(IDX_CONTROL, 8'h01);
    wr(IDX_FLAGS, 8'h00);
    chk_flags();
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    mOf = 0;
    chk_flags();
    // Backup mode: no battery check, fail detection still live, interrupt needs backup enable.
    supplyOk <= 1'h0;
    battLow <= ~battLow;
    loadLen = 0;
    midTick <= 1'h1;
    @(posedge ref_clk);
    midTick <= 1'h0;
    repeat (LOADC + 8) @(posedge ref_clk);
    chk(32'(loadLen), 32'h0);
    chk_flags();
    oscStop <= 1'h1;
    @(posedge ref_clk);
    oscStop <= 1'h0;
    repeat (3) @(posedge ref_clk);
    mOf = 1;
    chk_flags();
    chk(irqOeN, 1'h1);
    wr(IDX_ALARM1MO, 8'h20);
    chk(irqOeN, 1'h0);
    mBl = battLow;
    supplyOk <= 1'h1;
    // Century count wraps after four turns; leap follows the count on century years.
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 3; j++) begin
        div4 <= (j != 0);
        isCent <= (j == 2);
        repeat (3) @(posedge ref_clk);
        lm = (j == 1) || (j == 2 && mCent == 0);
        chk(leap, lm[0]);
        axi_read(IDX_STATUS, d, r);
        chk(d & 32'h7, 32'(mCent | (lm << LEAP_BIT)));
      end
      centTurn <= 1'h1;
      @(posedge ref_clk);
      centTurn <= 1'h0;
      mCent = (mCent + 1) % 4;
    end
    chk_flags();
    axi_read(8'h3F, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    axi_write(8'h3F, 8'hFF, r);
    chk(r, RESP_SLVERR);
    close_out();
  end
endmodule : test_rtc_status_and_square_wave
